/* File: logic/fac_audio_chain.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
// How it works
// - Line samples are scaled so the programmed peak level reaches full deviation.
// - The 2-bit attenuation code picks a capacity of 190, 301, 416 or 636 mV.
// - Silence detection compares level with separate low and high dBFS thresholds.
// - Low or high indication asserts only after the level holds past its duration.
// - Low and high indications are visible as outputs and status bits.
// - Compressor boosts below threshold by gain and compresses above it.
// - The compressor can be switched off for plain pass-through.
// - Attack and release rates set how fast compressor gain moves.
// - The limiter attenuates peaks over its threshold so deviation stays bounded at its output, ahead of pre-emphasis.
// - Limiter threshold is deviation plus ten percent.
// - Limiter attack completes within one sample.
// - Limiter recovery is programmable and resets to 5 ms.
// - Pre-emphasis boosts highs with a 50 or 75 us time constant.
module fac_audio_chain
   import fac_pkg::*;
(
   input  wire logic                       clk,         // 125 MHz
   input  wire logic                       resetn,      // Async, active low
   input  wire logic                       inValid,     // Sample strobe
   input  wire logic signed [SAMPLE_W-1:0] inSample,    // Line sample
   input  wire logic                       regWr,       // Write strobe
   input  wire logic                       regRd,       // Read strobe
   input  wire logic [4:0]                 regAddr,     // Word address
   input  wire logic [31:0]                regWdata,    // Write data
   output logic [31:0]                     regRdata_q,  // Read data
   output logic                            outValid_q,  // Result strobe
   output logic signed [SAMPLE_W-1:0]      outSample_q, // Result
   output logic                            lowLevel_q,  // Silence
   output logic                            highLevel_q, // Audio present
   output logic                            irq_q        // Level interrupt
);
   localparam int PW = 32;

   function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [PW-1:0] v);
      if (v > PW'(32767))
         sat = 16'sh7fff;
      else if (v < -PW'(32768))
         sat = -16'sh8000;
      else
         sat = v[SAMPLE_W-1:0];
   endfunction

   function automatic logic [15:0] mag(input logic signed [SAMPLE_W-1:0] v);
      mag = v[SAMPLE_W-1] ? 16'(-v) : 16'(v);
   endfunction

   // Rough dBFS of magnitude: 6 dB per leading bit
   function automatic logic signed [7:0] dbfs(input logic [15:0] m);
      logic signed [7:0] r;
      r = -8'sd96;
      for (int i = 0; i < 16; i++)
         if (m[i])
            r = 8'(6 * i - 90);
      dbfs = r;
   endfunction

   logic [9:0]  peakMv_q;
   logic [1:0]  atten_q;
   logic [15:0] deviation_q;
   logic signed [7:0] sqLow_q, sqHigh_q, compGain_q, compThr_q;
   logic [DUR_W-1:0]  durLow_q, durHigh_q;
   logic [RATE_W-1:0] attack_q, release_q, limRec_q;
   logic [2:0]  ctrl_q;
   logic [IRQ_W-1:0] irqStat_q, irqMask_q;

   // Stage 1: scale so peakMv maps to deviation
   logic [9:0]  capMv;
   logic [15:0] gainQ8;
   logic signed [PW-1:0] scaled;
   assign capMv = (atten_q == 2'h0) ? CAP_MV_0 :
                  (atten_q == 2'h1) ? CAP_MV_1 :
                  (atten_q == 2'h2) ? CAP_MV_2 : CAP_MV_3;
   // Full-scale input is capMv; full deviation at peakMv
   assign gainQ8 = (peakMv_q == 10'h0) ? 16'h0 :
                   16'((32'(capMv) * 32'(deviation_q)) / (32'(peakMv_q) * 32'd128));
   assign scaled = (PW'(inSample) * $signed({16'h0, gainQ8})) >>> 8;

   logic               s1Valid_q;
   logic signed [15:0] s1_q;
   logic [DUR_W-1:0]   lowCnt_q, highCnt_q;
   logic signed [7:0]  lvl;
   logic               belowLow, aboveHigh, lowHit, highHit;
   assign lvl       = dbfs(mag(s1_q));
   assign belowLow  = lvl < sqLow_q;
   assign aboveHigh = lvl > sqHigh_q;
   assign lowHit    = belowLow && (lowCnt_q >= durLow_q);
   assign highHit   = aboveHigh && (highCnt_q >= durHigh_q);

   // Stage 3: compressor, gain in dB tracked with attack/release
   logic signed [15:0] compDbQ8_q, targetDbQ8, compOut;
   logic signed [7:0]  over;
   logic [3:0]         shiftUp;
   logic [RATE_W-1:0]  relCnt_q;
   assign over = lvl - compThr_q;
   // Above threshold: gain*(1 - over/|thr|) keeps slope (gain+thr)/thr
   assign targetDbQ8 = (over <= 0) ? 16'(compGain_q) <<< 8 :
                       (16'(compGain_q) <<< 8) - 16'((32'(compGain_q) * 32'(over) * 256)
                                                   / 32'(-compThr_q));
   assign shiftUp = 4'(compDbQ8_q[15] ? 0 : compDbQ8_q >>> 8) / 4'd6;
   assign compOut = ctrl_q[CTRL_COMP_EN] ? sat(PW'(s1_q) <<< shiftUp) : s1_q;

   logic               s3Valid_q;
   logic signed [15:0] s3_q;

   // Stage 4: limiter
   logic [15:0] limThr;
   logic [15:0] limGainQ8_q;
   logic [31:0] limProd;
   logic [RATE_W-1:0] recCnt_q;
   logic        limOver;
   assign limThr  = deviation_q + 16'((32'(deviation_q) * 32'(LIM_HEAD_NUM)) >> 8);
   assign limProd = (32'(mag(s3_q)) * 32'(limGainQ8_q)) >> 8;
   assign limOver = limProd > 32'(limThr);
   logic signed [PW-1:0] limited;
   // One-sample attack: clip to threshold now, remember gain
   // Gain and threshold are unsigned; cast so the shift keeps the sign
   assign limited = limOver ? (s3_q[15] ? -$signed(PW'(limThr)) : $signed(PW'(limThr))) :
                    (PW'(s3_q) * $signed(PW'(limGainQ8_q))) >>> 8;

   logic               s4Valid_q;
   logic signed [15:0] s4_q, prev_q;
   logic signed [PW-1:0] emph;
   logic [8:0]         kEmph;
   assign kEmph = ctrl_q[CTRL_EMPH75] ? EMPH_K75 : EMPH_K50;
   assign emph  = PW'(s4_q) +
                  (((PW'(s4_q) - PW'(prev_q)) * $signed(PW'(kEmph))) >>> 8);

   // Register port
   logic [31:0] rdMux;
   always_comb begin
      unique case (regAddr)
         REG_LINE:    rdMux = {20'h0, atten_q, peakMv_q};
         REG_DEVIAT:  rdMux = {16'h0, deviation_q};
         REG_SQLVL:   rdMux = {16'h0, sqHigh_q, sqLow_q};
         REG_SQLODUR: rdMux = {16'h0, durLow_q};
         REG_SQHIDUR: rdMux = {16'h0, durHigh_q};
         REG_COMP:    rdMux = {16'h0, compThr_q, compGain_q};
         REG_ATTACK:  rdMux = {16'h0, attack_q};
         REG_RELEASE: rdMux = {16'h0, release_q};
         REG_LIMREC:  rdMux = {16'h0, limRec_q};
         REG_CTRL:    rdMux = {29'h0, ctrl_q};
         REG_STATUS:  rdMux = {30'h0, highLevel_q, lowLevel_q};
         REG_IRQSTAT: rdMux = {29'h0, irqStat_q};
         REG_IRQMASK: rdMux = {29'h0, irqMask_q};
         default:     rdMux = 32'h0;
      endcase
   end

   logic [IRQ_W-1:0] evt;
   // Hit terms stay true between samples, so each event waits for its stage strobe
   assign evt = {s3Valid_q && limOver,
                 s1Valid_q && highHit && !highLevel_q,
                 s1Valid_q && lowHit && !lowLevel_q};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         peakMv_q <= RST_PEAK_MV;
         atten_q <= RST_ATTEN;
         deviation_q <= RST_DEVIATION;
         sqLow_q <= RST_SQ_LOW;
         sqHigh_q <= RST_SQ_HIGH;
         durLow_q <= '0;
         durHigh_q <= '0;
         compGain_q <= RST_COMP_GAIN;
         compThr_q <= RST_COMP_THR;
         attack_q <= RST_ATTACK;
         release_q <= RST_RELEASE;
         limRec_q <= RST_LIM_REC;
         ctrl_q <= 3'h5;
         irqMask_q <= '0;
      end else if (regWr) begin
         unique case (regAddr)
            REG_LINE:    {atten_q, peakMv_q} <= regWdata[11:0];
            REG_DEVIAT:  deviation_q <= regWdata[15:0];
            REG_SQLVL:   {sqHigh_q, sqLow_q} <= regWdata[15:0];
            REG_SQLODUR: durLow_q <= regWdata[15:0];
            REG_SQHIDUR: durHigh_q <= regWdata[15:0];
            REG_COMP:    {compThr_q, compGain_q} <= regWdata[15:0];
            REG_ATTACK:  attack_q <= regWdata[15:0];
            REG_RELEASE: release_q <= regWdata[15:0];
            REG_LIMREC:  limRec_q <= regWdata[15:0];
            REG_CTRL:    ctrl_q <= regWdata[2:0];
            REG_IRQMASK: irqMask_q <= regWdata[IRQ_W-1:0];
            default:     ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdata_q <= '0;
         irqStat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         regRdata_q <= regRd ? rdMux : 32'h0;
         // Set beats a clear-on-read in the same cycle
         irqStat_q <= ((regRd && regAddr == REG_IRQSTAT) ? '0 : irqStat_q) | evt;
         irq_q <= |(irqStat_q & irqMask_q);
      end
   end

   // Stage 1 and silence detector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1Valid_q <= 1'b0;
         s1_q <= '0;
         lowCnt_q <= '0;
         highCnt_q <= '0;
         lowLevel_q <= 1'b0;
         highLevel_q <= 1'b0;
      end else begin
         s1Valid_q <= inValid;
         if (inValid)
            s1_q <= sat(scaled);
         if (s1Valid_q) begin
            lowCnt_q <= belowLow ? (lowHit ? lowCnt_q : lowCnt_q + 1'b1) : '0;
            highCnt_q <= aboveHigh ? (highHit ? highCnt_q : highCnt_q + 1'b1) : '0;
            if (lowHit) begin
               lowLevel_q <= 1'b1;
               highLevel_q <= 1'b0;
            end else if (highHit) begin
               highLevel_q <= 1'b1;
               lowLevel_q <= 1'b0;
            end
         end
      end
   end

   // Compressor
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s3Valid_q <= 1'b0;
         s3_q <= '0;
         compDbQ8_q <= '0;
         relCnt_q <= '0;
      end else begin
         s3Valid_q <= s1Valid_q;
         if (s1Valid_q) begin
            s3_q <= compOut;
            // Attack steps down by attack_q; release steps up one dB every release_q+1 samples
            if (targetDbQ8 < compDbQ8_q) begin
               compDbQ8_q <= (compDbQ8_q - targetDbQ8 > $signed(attack_q)) ?
                             compDbQ8_q - $signed(attack_q) : targetDbQ8;
               relCnt_q <= '0;
            end else if (relCnt_q >= release_q) begin
               compDbQ8_q <= (compDbQ8_q < targetDbQ8) ? compDbQ8_q + 16'sd256 : compDbQ8_q;
               relCnt_q <= '0;
            end else begin
               relCnt_q <= relCnt_q + 1'b1;
            end
         end
      end
   end

   // Limiter and pre-emphasis
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s4Valid_q <= 1'b0;
         s4_q <= '0;
         prev_q <= '0;
         limGainQ8_q <= 16'h0100;
         recCnt_q <= '0;
         outValid_q <= 1'b0;
         outSample_q <= '0;
      end else begin
         s4Valid_q <= s3Valid_q;
         outValid_q <= s4Valid_q;
         if (s3Valid_q) begin
            s4_q <= sat(limited);
            if (limOver) begin
               limGainQ8_q <= 16'((32'(limThr) << 8) / (32'(mag(s3_q)) + 32'd1));
               recCnt_q <= '0;
            end else if (recCnt_q >= limRec_q) begin
               limGainQ8_q <= 16'h0100;
            end else begin
               recCnt_q <= recCnt_q + 1'b1;
            end
         end
         if (s4Valid_q) begin
            prev_q <= s4_q;
            outSample_q <= ctrl_q[CTRL_EMPH_EN] ? sat(emph) : s4_q;
         end
      end
   end

   property p_lim_bound;
      @(posedge clk) disable iff (!resetn)
      s3Valid_q |=> (mag(s4_q) <= limThr + 16'd1);
   endproperty
   a_lim_bound: assert property (p_lim_bound) else $error("limiter overshoot");

   property p_order;
      @(posedge clk) disable iff (!resetn)
      inValid |-> ##4 outValid_q;
   endproperty
   a_order: assert property (p_order) else $error("sample lost in chain");

   property p_low_set;
      @(posedge clk) disable iff (!resetn)
      (s1Valid_q && lowHit) |=> lowLevel_q && !highLevel_q;
   endproperty
   a_low_set: assert property (p_low_set) else $error("low flag missed");

   property p_hold;
      @(posedge clk) disable iff (!resetn)
      (s1Valid_q && !belowLow && !aboveHigh) |=> $stable(lowLevel_q) && lowCnt_q == 0;
   endproperty
   a_hold: assert property (p_hold) else $error("between thresholds changed");

   property p_bypass;
      @(posedge clk) disable iff (!resetn)
      (s1Valid_q && !ctrl_q[CTRL_COMP_EN]) |=> s3_q == $past(s1_q);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass altered audio");

   property p_irq;
      @(posedge clk) disable iff (!resetn)
      (|(irqStat_q & irqMask_q)) |=> irq_q;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_rec;
      @(posedge clk) disable iff (!resetn)
      (s3Valid_q && !limOver && recCnt_q >= limRec_q) |=> limGainQ8_q == 16'h0100;
   endproperty
   a_rec: assert property (p_rec) else $error("limiter did not recover");

   property p_emph;
      @(posedge clk) disable iff (!resetn)
      (s4Valid_q && !ctrl_q[CTRL_EMPH_EN]) |=> outSample_q == $past(s4_q);
   endproperty
   a_emph: assert property (p_emph) else $error("emphasis bypass wrong");

   property p_lim_irq;
      @(posedge clk) disable iff (!resetn)
      (s3Valid_q && limOver) |=> irqStat_q[IRQ_LIM];
   endproperty
   a_lim_irq: assert property (p_lim_irq) else $error("limiter event not latched");
endmodule // fac_audio_chain

/* File: logic/fac_pkg.sv */
package fac_pkg;
   // Sample and coefficient widths, and clock rate
   localparam int SAMPLE_W = 16;
   localparam int LVL_W    = 10;
   localparam int DB_W     = 8;
   localparam int DUR_W    = 16;
   localparam int RATE_W   = 16;
   localparam int CLK_MHZ  = 125;

   // Register offsets on the plain port
   localparam logic [4:0] REG_LINE    = 5'h00;
   localparam logic [4:0] REG_DEVIAT  = 5'h01;
   localparam logic [4:0] REG_SQLVL   = 5'h02;
   localparam logic [4:0] REG_SQLODUR = 5'h03;
   localparam logic [4:0] REG_SQHIDUR = 5'h04;
   localparam logic [4:0] REG_COMP    = 5'h05;
   localparam logic [4:0] REG_ATTACK  = 5'h06;
   localparam logic [4:0] REG_RELEASE = 5'h07;
   localparam logic [4:0] REG_LIMREC  = 5'h08;
   localparam logic [4:0] REG_CTRL    = 5'h09;
   localparam logic [4:0] REG_STATUS  = 5'h0a;
   localparam logic [4:0] REG_IRQSTAT = 5'h0b;
   localparam logic [4:0] REG_IRQMASK = 5'h0c;

   // Peak capacities per attenuation code, millivolts
   localparam logic [9:0] CAP_MV_0 = 10'd190;
   localparam logic [9:0] CAP_MV_1 = 10'd301;
   localparam logic [9:0] CAP_MV_2 = 10'd416;
   localparam logic [9:0] CAP_MV_3 = 10'd636;

   // Reset values
   localparam logic [9:0]  RST_PEAK_MV   = 10'd636;
   localparam logic [1:0]  RST_ATTEN     = 2'h3;
   localparam logic [15:0] RST_DEVIATION = 16'h6000;
   localparam logic [7:0]  RST_SQ_LOW    = 8'hd0;   // -48 dBFS
   localparam logic [7:0]  RST_SQ_HIGH   = 8'hf8;   // -8 dBFS
   localparam logic [7:0]  RST_COMP_GAIN = 8'h0f;
   localparam logic [7:0]  RST_COMP_THR  = 8'he8;   // -24 dBFS
   localparam logic [15:0] RST_ATTACK    = 16'h0040;
   localparam logic [15:0] RST_RELEASE   = 16'h0400;

   // Limiter recovery default: 5 ms, in samples at 48 kHz
   localparam int LIM_REC_MS     = 5;
   localparam int SAMPLE_RATE_HZ = 48000;
   localparam logic [15:0] RST_LIM_REC = 16'(LIM_REC_MS * SAMPLE_RATE_HZ / 1000);

   // Ten percent headroom as 26/256 of deviation
   localparam logic [7:0] LIM_HEAD_NUM = 8'd26;

   // Control bits
   localparam int CTRL_COMP_EN = 0;
   localparam int CTRL_EMPH75  = 1;
   localparam int CTRL_EMPH_EN = 2;

   // Interrupt bits
   localparam int IRQ_LOW  = 0;
   localparam int IRQ_HIGH = 1;
   localparam int IRQ_LIM  = 2;
   localparam int IRQ_W    = 3;

   // Pre-emphasis feed-forward weights, Q8 at 48 kHz
   localparam logic [8:0] EMPH_K50 = 9'd230;
   localparam logic [8:0] EMPH_K75 = 9'd242;

   typedef struct packed {
      logic                       valid;
      logic signed [SAMPLE_W-1:0] sample;
   } fac_sample_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [31:0] wdata;
   } fac_bus_t;
endpackage

/* File: test/fac_audio_source.sv */
`timescale 1ns/10ps
module fac_audio_source
   import fac_pkg::*;
(
   input  wire logic                       clk,         // Bench clock
   input  wire logic                       resetn,      // Async, active low
   input  wire logic                       start,       // Begin a burst
   input  wire logic [7:0]                 count,       // Samples in burst
   input  wire logic signed [SAMPLE_W-1:0] amp,         // Peak value
   input  wire logic [3:0]                 gap,         // Idle cycles between samples
   output logic                            srcValid_q,  // Sample strobe
   output logic signed [SAMPLE_W-1:0]      srcSample_q, // Sample value
   output logic                            busy         // Burst running
);
   logic [7:0] left_q;
   logic [3:0] wait_q;
   logic       neg_q;

   assign busy = (left_q != 8'h0) || srcValid_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_q      <= 8'h0;
         wait_q      <= 4'h0;
         neg_q       <= 1'b0;
         srcValid_q  <= 1'b0;
         srcSample_q <= 16'sh0;
      end else if (start) begin
         left_q     <= count;
         wait_q     <= 4'h0;
         srcValid_q <= 1'b0;
      end else if (left_q != 8'h0 && wait_q == 4'h0) begin
         srcValid_q  <= 1'b1;
         srcSample_q <= neg_q ? -amp : amp;
         neg_q       <= ~neg_q;
         left_q      <= left_q - 8'h1;
         wait_q      <= gap;
      end else begin
         // Stale data scrambled so the sink cannot lean on it
         srcValid_q  <= 1'b0;
         srcSample_q <= ~srcSample_q;
         if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
      end
   end
endmodule // fac_audio_source

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top
   import fac_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic [4:0]  addr;
      logic [31:0] data;
      logic [31:0] exp;
   } fac_row_t;

   localparam int LIM_BOUND = int'(RST_DEVIATION) + (int'(RST_DEVIATION) * int'(LIM_HEAD_NUM)) / 256;

   logic                       clk, resetn, regWr, regRd, start, busy, inValid;
   logic                       outValid_q, lowLevel_q, highLevel_q, irq_q;
   logic [4:0]                 regAddr;
   logic [31:0]                regWdata, regRdata_q, rd;
   logic [7:0]                 count;
   logic [3:0]                 gap, inHist;
   logic signed [SAMPLE_W-1:0] amp, inSample, outSample_q;
   int                         absOut, compares, miscompares;

   fac_row_t rows [0:24] = '{
      '{1'b0, REG_LINE, 32'h0, 32'he7c},
      '{1'b0, REG_DEVIAT, 32'h0, 32'h6000},
      '{1'b0, REG_SQLVL, 32'h0, 32'hf8d0},
      '{1'b0, REG_COMP, 32'h0, 32'he80f},
      '{1'b0, REG_ATTACK, 32'h0, 32'h40},
      '{1'b0, REG_RELEASE, 32'h0, 32'h400},
      '{1'b0, REG_LIMREC, 32'h0, 32'hf0},
      '{1'b0, REG_CTRL, 32'h0, 32'h5},
      '{1'b0, REG_IRQMASK, 32'h0, 32'h0},
      '{1'b0, REG_IRQSTAT, 32'h0, 32'h0},
      '{1'b0, REG_STATUS, 32'h0, 32'h0},
      '{1'b1, REG_LINE, 32'h096, 32'h096},
      '{1'b1, REG_LINE, 32'h4fa, 32'h4fa},
      '{1'b1, REG_LINE, 32'h990, 32'h990},
      '{1'b1, REG_LINE, 32'he58, 32'he58},
      '{1'b1, 5'h1f, 32'h1234, 32'h0},
      '{1'b1, REG_STATUS, 32'h3, 32'h0},
      '{1'b1, REG_LIMREC, 32'h60, 32'h60},
      '{1'b1, REG_SQLODUR, 32'h4, 32'h4},
      '{1'b1, REG_SQHIDUR, 32'h4, 32'h4},
      '{1'b1, REG_SQLVL, 32'hecd0, 32'hecd0},
      '{1'b1, REG_COMP, 32'he80f, 32'he80f},
      '{1'b1, REG_CTRL, 32'h1, 32'h1},
      '{1'b1, REG_IRQMASK, 32'h1, 32'h1},
      '{1'b0, REG_DEVIAT, 32'h0, 32'h6000}
   };

   fac_audio_chain dut_u (.clk(clk), .resetn(resetn), .inValid(inValid), .inSample(inSample),
      .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata_q(regRdata_q), .outValid_q(outValid_q), .outSample_q(outSample_q),
      .lowLevel_q(lowLevel_q), .highLevel_q(highLevel_q), .irq_q(irq_q));

   fac_audio_source src_u (.clk(clk), .resetn(resetn), .start(start), .count(count),
      .amp(amp), .gap(gap), .srcValid_q(inValid), .srcSample_q(inSample), .busy(busy));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   assign absOut = (outSample_q < 0) ? -int'(outSample_q) : int'(outSample_q);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Counts: compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic regRead(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata_q;
   endtask

   // Settle time covers pipeline plus indication lag
   task automatic burst(input logic [7:0] n, input logic signed [15:0] a, input logic [3:0] g);
      int k;
      @(posedge clk);
      start <= 1'b1;
      count <= n;
      amp   <= a;
      gap   <= g;
      @(posedge clk);
      start <= 1'b0;
      // Let the source take the start edge before busy is read
      #1;
      for (k = 0; k < 500 && busy; k++) begin
         @(posedge clk);
         #1;
      end
      if (busy) begin
         miscompares++;
         $display("ERROR %0t: source never finished", $time);
         conclude();
      end
      repeat (8) @(posedge clk);
      #1;
   endtask

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inHist <= 4'h0;
      end else begin
         inHist <= {inHist[2:0], inValid};
         if (inHist[3] || outValid_q) check({31'h0, outValid_q}, {31'h0, inHist[3]});
         if (outValid_q) check({31'h0, absOut <= LIM_BOUND}, 32'h1);
      end
   end

   initial begin
      compares = 0;
      miscompares = 0;
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 5'h0;
      regWdata = 32'h0;
      start = 1'b0;
      count = 8'h0;
      amp = 16'sh0;
      gap = 4'h0;
      repeat (3) @(posedge clk);
      #1 check({27'h0, outValid_q, lowLevel_q, highLevel_q, irq_q, 1'b0}, 32'h0);
      check(regRdata_q, 32'h0);
      @(posedge clk);
      resetn <= 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         if (rows[i].wr) regWrite(rows[i].addr, rows[i].data);
         regRead(rows[i].addr, rd);
         check(rd, rows[i].exp);
      end
      $display("test register table done");
      burst(8'd3, 16'sh0001, 4'd3);
      check({31'h0, lowLevel_q}, 32'h0);
      burst(8'd3, 16'sh0001, 4'd3);
      check({31'h0, lowLevel_q}, 32'h1);
      check({31'h0, irq_q}, 32'h1);
      regRead(REG_STATUS, rd);
      check(rd, 32'h1);
      regRead(REG_IRQSTAT, rd);
      check(rd & 32'h1, 32'h1);
      regRead(REG_IRQSTAT, rd);
      check(rd & 32'h1, 32'h0);
      repeat (2) @(posedge clk);
      #1 check({31'h0, irq_q}, 32'h0);
      $display("test low level done");
      burst(8'd8, 16'sh0400, 4'd3);
      check({30'h0, highLevel_q, lowLevel_q}, 32'h1);
      // Back-to-back full-scale peaks stay above the high threshold but under limThr, so the limiter is not engaged
      burst(8'd3, 16'sh7fff, 4'd0);
      check({31'h0, highLevel_q}, 32'h0);
      burst(8'd3, 16'sh7fff, 4'd0);
      check({31'h0, highLevel_q}, 32'h1);
      burst(8'd8, 16'sh0400, 4'd3);
      check({31'h0, highLevel_q}, 32'h1);
      $display("test high level done");
      // Compressor off for the bypass path; a low programmed peak overdrives the limiter
      regWrite(REG_CTRL, 32'h0);
      regWrite(REG_LINE, 32'h4c8);
      burst(8'd4, 16'sh7fff, 4'd0);
      regRead(REG_IRQSTAT, rd);
      check(rd & 32'h4, 32'h4);
      check({31'h0, highLevel_q}, 32'h1);
      $display("test limiter done");
      regWrite(REG_CTRL, 32'h6);
      regRead(REG_CTRL, rd);
      check(rd, 32'h6);
      burst(8'd2, 16'sh0001, 4'd1);
      check({30'h0, highLevel_q, lowLevel_q}, 32'h2);
      $display("test emphasis done");
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      #1 check({28'h0, outValid_q, lowLevel_q, highLevel_q, irq_q}, 32'h0);
      @(posedge clk);
      resetn <= 1'b1;
      regRead(REG_LIMREC, rd);
      check(rd, 32'hf0);
      $display("test second reset done");
      conclude();
   end
endmodule // tb_top
